// ---- mccb_pkg.sv ----
// Purpose: shared constants for the multi-controller bus coordination block
// Assumes: 32-bit register words on an Avalon-MM slave, byte addressing
// Notes: strap pair {strapHigh, strapLow} selects controller number
package mccb_pkg;
  // controller numbers and register bases
  localparam logic [1:0] MCCB_ID_MAIN = 2'h0;
  localparam logic [35:0] MCCB_BASE_ID0 = 36'h01FA00000;
  localparam logic [35:0] MCCB_BASE_ID1 = 36'h01F800000;
  localparam logic [35:0] MCCB_BASE_ID2 = 36'h01F600000;
  localparam logic [35:0] MCCB_BASE_ID3 = 36'h01F400000;
  localparam logic [35:0] MCCB_BOOT_BASE = 36'h01FC00000;
  // decode windows compare address bits 35:21 (2MB)
  localparam int MCCB_DEC_LSB = 21;
  // topology field encodings
  localparam logic [1:0] MCCB_TOPO_SINGLE = 2'h0;
  localparam logic [1:0] MCCB_TOPO_MULTI_GOOD = 2'h1;
  localparam logic [1:0] MCCB_TOPO_MULTI_BAD = 2'h2;
  // register offsets (byte addresses)
  localparam logic [3:0] MCCB_REG_STATUS = 4'h0;
  localparam logic [3:0] MCCB_REG_TIMEOUT = 4'h4;
  localparam logic [3:0] MCCB_REG_CONFIG = 4'h8;
  localparam logic [3:0] MCCB_REG_FIFO = 4'hC;
  // status register fields
  localparam int MCCB_ST_TOPO_LSB = 0;
  localparam int MCCB_ST_ID_LSB = 4;
  localparam int MCCB_ST_INIT_BIT = 8;
  // reset values
  localparam logic [1:0] MCCB_TOPO_RST = 2'h0;
  localparam logic [15:0] MCCB_TIMEOUT_RST = 16'h0000;
  localparam logic [7:0] MCCB_CFG_RST = 8'h00;
  // configuration defaults when no serial memory is present
  localparam logic [7:0] MCCB_CFG_DEFAULT = 8'h00;
  localparam logic [7:0] MCCB_CFG_LEGAL_MASK = 8'h7F;
  localparam int MCCB_CFG_BITS = 8;
  // write fifo thresholds in items
  localparam logic [4:0] MCCB_WM_SINGLE = 5'h06;
  localparam logic [4:0] MCCB_WM_MULTI = 5'h05;
  localparam int MCCB_FIFO_DEPTH = 16;
  // init state machine
  typedef enum logic [3:0] {
    MCCB_INIT_IDLE = 4'b0001,
    MCCB_INIT_SHIFT = 4'b0010,
    MCCB_INIT_SEND = 4'b0100,
    MCCB_INIT_DONE = 4'b1000
  } mccb_init_t;
endpackage

// ---- mccb_coordinator.sv ----
// Purpose: lets several system controllers share one cpu bus
// Assumes: all inputs synchronous to mclk; one cpu read outstanding
// Notes: peer data paths are external; this block steers who answers
//
// Chosen here: register access over Avalon-MM and the register offsets.
module mccb_coordinator
  import mccb_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  // straps, pulled low when unconnected
  input wire logic id_strap_low,
  input wire logic id_strap_high,
  // cpu request, one cycle per address item
  input wire logic cpuReqValid,
  input wire logic cpuReqWrite,
  input wire logic cpuReqBoot,
  input wire logic [35:0] cpuReqAddr,
  input wire logic cpuDataValid,
  // fifo drain from the local resources
  input wire logic fifoPop,
  // any claimed local target wants this read
  input wire logic localClaim,
  // shared valid strobe pin
  input wire logic shared_valid_strobe_n_in,
  output logic shared_valid_strobe_n_out,
  output logic shared_valid_strobe_n_oe,
  // write ready pin and local ready
  input wire logic write_ready_n_in,
  output logic write_ready_n_out,
  output logic write_ready_n_oe,
  output logic local_write_ready_n,
  // zero and boot answers, discard and flush markers
  output logic zeroAnswer,
  output logic zeroParityBad,
  output logic bootAnswer,
  output logic readDiscard,
  output logic writeFlush,
  // serial configuration memory
  input wire logic cfgPresent,
  input wire logic cfgSerialIn,
  output logic cfgClk,
  output logic [7:0] cpuInitData,
  output logic initDone,
  // avalon-mm slave
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest
);
  logic [1:0] idFf;
  logic [1:0] topoFf;
  logic [15:0] toLoadFf;
  logic [15:0] toCntFf;
  logic readPendFf;
  logic [4:0] fifoCntFf;
  logic [7:0] cfgFf;
  logic [2:0] bitCntFf;
  mccb_init_t initFf;
  mccb_init_t nxt_init;
  logic ackFf;
  logic zeroFf, parFf, bootFf, discFf, flushFf, cfgClkFf, doneFf;
  logic validOutFf, validOeFf, wrOutFf, wrOeFf, localRdyFf;
  logic [31:0] rdataFf;

  // strap latch and address decode
  wire logic isMain = (idFf == MCCB_ID_MAIN);
  wire logic multi = (topoFf != MCCB_TOPO_SINGLE);
  wire logic [35:0] regBase = (idFf == 2'h0) ? MCCB_BASE_ID0 :
                              (idFf == 2'h1) ? MCCB_BASE_ID1 :
                              (idFf == 2'h2) ? MCCB_BASE_ID2 :
                              MCCB_BASE_ID3;
  wire logic regHit = cpuReqAddr[35:MCCB_DEC_LSB] ==
                      regBase[35:MCCB_DEC_LSB];
  wire logic bootHit = isMain && cpuReqBoot &&
                       cpuReqAddr[35:MCCB_DEC_LSB] ==
                       MCCB_BOOT_BASE[35:MCCB_DEC_LSB];
  wire logic claim = regHit || localClaim || bootHit;
  wire logic newRead = cpuReqValid && !cpuReqWrite;
  wire logic newWrite = cpuReqValid && cpuReqWrite;
  // response seen: a peer's on the shared strobe while we do not drive it, or our own zero or boot answer
  wire logic peerResp = multi && !shared_valid_strobe_n_in &&
                        !validOeFf;
  wire logic anyResp = peerResp || zeroFf || bootFf;
  wire logic toExpire = readPendFf && multi && (toCntFf == 16'h0001);
  wire logic zeroNow = isMain && readPendFf &&
                       (!multi || toExpire);
  // fifo depth tracking for the write-ready watermark
  wire logic push = newWrite && claim || cpuDataValid && claim;
  wire logic pop = fifoPop && (fifoCntFf != 5'h00);
  wire logic [4:0] wMark = multi ? MCCB_WM_MULTI : MCCB_WM_SINGLE;
  wire logic full = fifoCntFf >= wMark;
  // a write lands only at the edge where waitrequest is sampled low
  wire logic avWr = avs_write && ackFf;
  wire logic avRd = avs_read && !ackFf;

  // straps caught while reset is held, kept until next reset
  always_ff @(posedge mclk) begin
    if (rst) begin
      idFf <= {id_strap_high, id_strap_low};
    end
  end

  // software-visible topology and timeout load
  always_ff @(posedge mclk) begin
    if (rst) begin
      topoFf <= MCCB_TOPO_RST;
      toLoadFf <= MCCB_TIMEOUT_RST;
    end else if (avWr && avs_address == MCCB_REG_STATUS) begin
      topoFf <= avs_writedata[MCCB_ST_TOPO_LSB +: 2];
    end else if (avWr && avs_address == MCCB_REG_TIMEOUT) begin
      toLoadFf <= avs_writedata[15:0];
    end
  end

  // pending read and timeout counter
  always_ff @(posedge mclk) begin
    if (rst) begin
      readPendFf <= 1'b0;
      toCntFf <= 16'h0000;
    end else if (anyResp) begin
      readPendFf <= 1'b0;
      toCntFf <= toLoadFf;
    end else if (newRead && !claim) begin
      readPendFf <= 1'b1;
      toCntFf <= toLoadFf;
    end else if (readPendFf && toCntFf != 16'h0000) begin
      toCntFf <= toCntFf - 16'h0001;
    end
  end

  // answer strobes and flush markers
  always_ff @(posedge mclk) begin
    if (rst) begin
      zeroFf <= 1'b0;
      parFf <= 1'b0;
      bootFf <= 1'b0;
      discFf <= 1'b0;
      flushFf <= 1'b0;
    end else begin
      zeroFf <= zeroNow && !zeroFf;
      parFf <= (topoFf == MCCB_TOPO_MULTI_BAD);
      bootFf <= newRead && bootHit && doneFf;
      discFf <= anyResp;
      flushFf <= newWrite && !claim;
    end
  end

  // write fifo count, saturating at depth
  always_ff @(posedge mclk) begin
    if (rst) begin
      fifoCntFf <= 5'h00;
    end else if (push && !pop && fifoCntFf != 5'(MCCB_FIFO_DEPTH)) begin
      fifoCntFf <= fifoCntFf + 5'h01;
    end else if (pop && !push) begin
      fifoCntFf <= fifoCntFf - 5'h01;
    end
  end

  // pin drivers: valid strobe and write ready
  always_ff @(posedge mclk) begin
    if (rst) begin
      validOutFf <= 1'b1;
      validOeFf <= 1'b0;
      wrOutFf <= 1'b1;
      wrOeFf <= 1'b0;
      localRdyFf <= 1'b0;
    end else begin
      validOutFf <= !(zeroNow || bootHit && newRead);
      validOeFf <= !multi || zeroNow || claim && newRead;
      wrOutFf <= full;
      wrOeFf <= !multi;
      localRdyFf <= full && claim;
    end
  end

  // init sequence: clock serial memory or default, fix, send
  always_comb begin
    nxt_init = initFf;
    case (initFf)
      MCCB_INIT_IDLE: nxt_init = cfgPresent ? MCCB_INIT_SHIFT :
                                             MCCB_INIT_SEND;
      MCCB_INIT_SHIFT: if (bitCntFf == 3'h7 && cfgClkFf) begin
        nxt_init = MCCB_INIT_SEND;
      end
      MCCB_INIT_SEND: nxt_init = MCCB_INIT_DONE;
      MCCB_INIT_DONE: nxt_init = MCCB_INIT_DONE;
      default: nxt_init = MCCB_INIT_IDLE;
    endcase
  end

  // serial shift; only the main controller drives the clock, others stay in shift when serial memory is present
  always_ff @(posedge mclk) begin
    if (rst) begin
      initFf <= MCCB_INIT_IDLE;
      cfgFf <= MCCB_CFG_RST;
      bitCntFf <= 3'h0;
      cfgClkFf <= 1'b0;
      doneFf <= 1'b0;
    end else begin
      initFf <= nxt_init;
      cfgClkFf <= (initFf == MCCB_INIT_SHIFT) && !cfgClkFf && isMain;
      if (initFf == MCCB_INIT_IDLE && !cfgPresent) begin
        cfgFf <= MCCB_CFG_DEFAULT;
      end else if (initFf == MCCB_INIT_SHIFT && cfgClkFf) begin
        cfgFf <= {cfgFf[6:0], cfgSerialIn};
        bitCntFf <= bitCntFf + 3'h1;
      end else if (initFf == MCCB_INIT_SEND) begin
        cfgFf <= cfgFf & MCCB_CFG_LEGAL_MASK;
      end
      doneFf <= (initFf == MCCB_INIT_SEND) || doneFf;
    end
  end

  // avalon slave: one wait cycle, then ack
  always_ff @(posedge mclk) begin
    if (rst) begin
      ackFf <= 1'b0;
      rdataFf <= 32'h00000000;
    end else begin
      ackFf <= (avs_read || avs_write) && !ackFf;
      if (avRd) begin
        case (avs_address)
          MCCB_REG_STATUS: rdataFf <= {23'h000000, doneFf, 2'h0, idFf,
                                       2'h0, topoFf};
          MCCB_REG_TIMEOUT: rdataFf <= {16'h0000, toCntFf};
          MCCB_REG_CONFIG: rdataFf <= {24'h000000, cfgFf};
          MCCB_REG_FIFO: rdataFf <= {27'h0000000, fifoCntFf};
          default: rdataFf <= 32'h00000000;
        endcase
      end
    end
  end

  assign avs_waitrequest = !ackFf;
  assign avs_readdata = rdataFf;
  assign shared_valid_strobe_n_out = validOutFf;
  assign shared_valid_strobe_n_oe = validOeFf;
  assign write_ready_n_out = wrOutFf;
  assign write_ready_n_oe = wrOeFf;
  assign local_write_ready_n = localRdyFf;
  assign zeroAnswer = zeroFf;
  assign zeroParityBad = parFf;
  assign bootAnswer = bootFf;
  assign readDiscard = discFf;
  assign writeFlush = flushFf;
  assign cfgClk = cfgClkFf;
  assign cpuInitData = cfgFf;
  assign initDone = doneFf;
endmodule

// ---- mccb_properties.sv ----
// Purpose: port-level checks for mccb_coordinator
// Assumes: straps change only while rst is high
// Notes: mode-dependent timing is checked by the bench
module mccb_properties (
  input wire logic mclk,
  input wire logic rst,
  input wire logic id_strap_low,
  input wire logic id_strap_high,
  input wire logic cfgPresent,
  input wire logic cfgClk,
  input wire logic initDone,
  input wire logic zeroAnswer,
  input wire logic bootAnswer,
  input wire logic readDiscard,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);
  // register bus answers exactly one cycle after a request is taken
  property p_ack_next;
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
  endproperty
  a_ack_next: assert property (p_ack_next)
    else $error("register access not answered after one cycle");
  property p_ack_once;
    !avs_waitrequest |=> avs_waitrequest;
  endproperty
  a_ack_once: assert property (p_ack_once)
    else $error("register acknowledge held longer than one cycle");
  // zero answers are single pulses followed by a discard
  property p_zero_pulse;
    zeroAnswer |=> !zeroAnswer;
  endproperty
  a_zero_pulse: assert property (p_zero_pulse)
    else $error("zero answer longer than one cycle");
  property p_discard;
    zeroAnswer |=> readDiscard;
  endproperty
  a_discard: assert property (p_discard)
    else $error("no read discard after a response");
  // only the main controller answers unclaimed and boot reads
  property p_zero_main;
    zeroAnswer |-> !id_strap_low && !id_strap_high;
  endproperty
  a_zero_main: assert property (p_zero_main)
    else $error("zero answer from a secondary controller");
  property p_boot_main;
    bootAnswer |-> initDone && !id_strap_low && !id_strap_high;
  endproperty
  a_boot_main: assert property (p_boot_main)
    else $error("boot answer outside main after init");
  // serial memory is only clocked when it exists; init stays done
  property p_cfg_clk;
    $rose(cfgClk) |-> cfgPresent;
  endproperty
  a_cfg_clk: assert property (p_cfg_clk)
    else $error("serial clock without serial memory");
  property p_init_hold;
    initDone |=> initDone;
  endproperty
  a_init_hold: assert property (p_init_hold)
    else $error("init done dropped without reset");
  c_zero: cover property (zeroAnswer);
  c_boot: cover property (bootAnswer);
  c_cfg: cover property ($rose(cfgClk));
endmodule

// ---- mccb_peer_model.sv ----
// Purpose: far side of the cpu bus: peers, ready network, serial memory
// Assumes: one peer whose local ready is driven by the bench
// Notes: serial memory rotates a fixed pattern on each clock it gets
module mccb_peer_model (
  input wire logic mclk,
  input wire logic local_write_ready_n,
  input wire logic peerReadyN,
  input wire logic write_ready_n_out,
  input wire logic write_ready_n_oe,
  input wire logic cfgClk,
  output logic write_ready_n_in,
  output logic cfgSerialIn
);
  timeunit 1ns;
  timeprecision 1ns;
  logic orReg_ff = 1'b1;
  logic [7:0] rom_ff = 8'hA5;
  // or of all local readies, registered on the bus clock
  always_ff @(posedge mclk) begin
    orReg_ff <= local_write_ready_n | peerReadyN;
  end
  // pin level: device drives it in single mode, the network otherwise
  assign write_ready_n_in = write_ready_n_oe ? write_ready_n_out : orReg_ff;
  // serial memory shifts out one bit per received clock
  always @(posedge cfgClk) begin
    rom_ff <= {rom_ff[6:0], rom_ff[7]};
  end
  assign cfgSerialIn = rom_ff[7];
endmodule

// ---- multi_controller_cpu_bus_coordination_tb_top.sv ----
// Purpose: self-checking bench for mccb_coordinator
// Assumes: timeout loaded with 20 cycles in multi mode
// Notes: a monitor pops expected read data and zero parities from queues
module multi_controller_cpu_bus_coordination_tb_top import mccb_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk = 0, rst = 1, id_strap_low = 0, id_strap_high = 0;
  logic cpuReqValid = 0, cpuReqWrite = 0, cpuReqBoot = 0, cpuDataValid = 0;
  logic fifoPop = 0, localClaim = 0, cfgPresent = 0, peerReadyN = 0;
  logic peerValidN = 1, avs_read = 0, avs_write = 0;
  logic [35:0] cpuReqAddr = '0;
  logic [3:0] avs_address = '0;
  logic [31:0] avs_writedata = '0, avs_readdata, rdMask = '1;
  logic shared_valid_strobe_n_in, shared_valid_strobe_n_out;
  logic shared_valid_strobe_n_oe, write_ready_n_in, write_ready_n_out;
  logic write_ready_n_oe, local_write_ready_n, zeroAnswer, zeroParityBad;
  logic bootAnswer, readDiscard, writeFlush, cfgSerialIn, cfgClk, initDone;
  logic avs_waitrequest;
  logic [7:0] cpuInitData;
  int fails = 0, n_tests = 0, seed = 38197, nBoot = 0;
  logic [31:0] rdQ[$];
  logic zeroQ[$];
  mccb_coordinator u_dut (.mclk, .rst, .id_strap_low, .id_strap_high,
    .cpuReqValid, .cpuReqWrite, .cpuReqBoot, .cpuReqAddr, .cpuDataValid,
    .fifoPop, .localClaim, .shared_valid_strobe_n_in,
    .shared_valid_strobe_n_out, .shared_valid_strobe_n_oe, .write_ready_n_in,
    .write_ready_n_out, .write_ready_n_oe, .local_write_ready_n, .zeroAnswer,
    .zeroParityBad, .bootAnswer, .readDiscard, .writeFlush, .cfgPresent,
    .cfgSerialIn, .cfgClk, .cpuInitData, .initDone, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest);
  mccb_peer_model u_peer (.mclk, .local_write_ready_n, .peerReadyN,
    .write_ready_n_out, .write_ready_n_oe, .cfgClk, .write_ready_n_in,
    .cfgSerialIn);
  // shared strobe: device level when enabled, else the peer's
  assign shared_valid_strobe_n_in = shared_valid_strobe_n_oe ?
    shared_valid_strobe_n_out : peerValidN;
  initial begin
    forever #10 mclk = ~mclk;
  end
  task automatic check(input logic [31:0] seen, exp, input string what);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic do_reset(input logic hi, lo, cp);
    rst <= 1;
    id_strap_high <= hi;
    id_strap_low <= lo;
    cfgPresent <= cp;
    repeat (16) @(posedge mclk);
    rst <= 0;
  endtask
  // register access: hold the request until waitrequest is sampled low
  task automatic avs(input logic wr, input logic [3:0] a,
    input logic [31:0] d, exp);
    int n;
    n = 0;
    if (!wr)
      rdQ.push_back(exp);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !wr;
    avs_write <= wr;
    do begin
      @(posedge mclk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (n >= 50)
      fails++;
    avs_read <= 0;
    avs_write <= 0;
    @(posedge mclk);
  endtask
  task automatic cpu_read(input logic claim, boot, expZero, par);
    logic [31:0] r;
    r = $random(seed);
    if (expZero)
      zeroQ.push_back(par);
    cpuReqValid <= 1;
    cpuReqBoot <= boot;
    localClaim <= claim;
    // boot fetches hit the boot window; others sit above every base
    cpuReqAddr <= boot ? {MCCB_BOOT_BASE[35:21], r[20:0]} :
      {1'b1, r, 3'h0};
    @(posedge mclk);
    cpuReqValid <= 0;
  endtask
  task automatic settle(input int n, input string name);
    repeat (n) @(posedge mclk);
    check(zeroQ.size(), 0, "zero answers owed");
    $display("test %s done", name);
  endtask
  task automatic wait_init();
    int n;
    n = 0;
    while (initDone !== 1'b1 && n < 3000) begin
      @(posedge mclk);
      n++;
    end
    check(initDone, 1, "initDone");
  endtask
  // monitor: compare each result with the oldest expectation
  always @(posedge mclk) begin
    if (bootAnswer === 1'b1)
      nBoot++;
    if (avs_read === 1'b1 && avs_waitrequest === 1'b0)
      check(avs_readdata & rdMask, rdQ.pop_front(), "readdata");
    if (zeroAnswer === 1'b1 && zeroQ.size() == 0)
      check(1, 0, "unexpected zeroAnswer");
    else if (zeroAnswer === 1'b1)
      check(zeroParityBad, zeroQ.pop_front(), "parity");
  end
  initial begin
    repeat (20000) @(posedge mclk);
    fails++;
    final_report();
  end
  initial begin
    do_reset(0, 0, 0);
    wait_init();
    check(cpuInitData, MCCB_CFG_DEFAULT & MCCB_CFG_LEGAL_MASK, "cfg");
    check(write_ready_n_oe, 1, "ready oe single");
    avs(0, MCCB_REG_STATUS, 0, 32'h100);
    avs(0, MCCB_REG_TIMEOUT, 0, 0);
    avs(0, 4'h2, 0, 0);
    cpu_read(0, 0, 1, 0);
    settle(6, "single unclaimed");
    cpu_read(1, 0, 0, 0);
    settle(6, "claimed read");
    cpu_read(0, 1, 0, 0);
    settle(10, "boot fetch");
    check(nBoot, 1, "boot answers");
    avs(1, MCCB_REG_TIMEOUT, 20, 0);
    avs(1, MCCB_REG_STATUS, {30'h0, MCCB_TOPO_MULTI_GOOD}, 0);
    @(posedge mclk);
    check(write_ready_n_oe, 0, "ready oe multi");
    cpu_read(0, 0, 1, 0);
    repeat (4) @(posedge mclk);
    check(zeroQ.size(), 1, "early zero");
    settle(40, "multi timeout");
    avs(1, MCCB_REG_STATUS, {30'h0, MCCB_TOPO_MULTI_BAD}, 0);
    cpu_read(0, 0, 1, 1);
    settle(40, "bad parity");
    rdMask = 32'hFF;
    for (int i = 1; i < 4; i++) begin
      do_reset(i[1], i[0], 1);
      avs(0, MCCB_REG_STATUS, 0, {26'h0, i[1:0], 4'h0});
      cpu_read(0, 1, 0, 0);
      settle(30, "secondary id");
    end
    check(nBoot, 1, "boot answers");
    id_strap_high <= 0;
    id_strap_low <= 0;
    @(posedge mclk);
    cpu_read(0, 0, 0, 0);
    settle(6, "strap hold");
    do_reset(0, 0, 1);
    wait_init();
    // serial memory pattern after one rotation, read over eight clocks, legal bits kept
    check(cpuInitData, 8'h4B & MCCB_CFG_LEGAL_MASK, "cfg serial");
    final_report();
  end
endmodule
bind mccb_coordinator mccb_properties u_props (.mclk, .rst, .id_strap_low,
  .id_strap_high, .cfgPresent, .cfgClk, .initDone, .zeroAnswer, .bootAnswer,
  .readDiscard, .avs_read, .avs_write, .avs_waitrequest);
